/* File: sram_pin_pkg.sv */
// Shared constants and types for the pipelined SRAM pin control
package sram_pin_pkg;
    localparam int ADDR_W       = 18;
    localparam int LANES        = 4;
    localparam int LANE_W       = 8;
    localparam int BURST_W      = 2;
    localparam int FIFO_DEPTH   = 16;
    localparam int SLEEP_CYCLES = 2;
    localparam int IR_W         = 2;

    localparam logic [IR_W-1:0]    IR_CAPTURE    = 2'h1;
    localparam logic [BURST_W-1:0] BURST_START   = 2'h0;
    localparam logic [BURST_W-1:0] BURST_STEP    = 2'h1;
    localparam logic [1:0]         SLEEP_LAST    = 2'(SLEEP_CYCLES - 1);
    localparam logic [2:0]         ASYNC_RST_VAL = 3'h5;
    localparam int                 SYNC_OE       = 0;
    localparam int                 SYNC_SLEEP    = 1;
    localparam int                 SYNC_MODE     = 2;

    typedef struct packed {
        logic [LANES-1:0]        parity_lines;
        logic [LANES*LANE_W-1:0] data_lines;
    } data_word_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0]  byte_write_select_n;
        data_word_t        word;
    } wr_entry_t;

    typedef enum logic [3:0] {
        TAP_RESET   = 4'h0,
        TAP_IDLE    = 4'h1,
        TAP_SEL_DR  = 4'h2,
        TAP_CAP_DR  = 4'h3,
        TAP_SH_DR   = 4'h4,
        TAP_EX1_DR  = 4'h5,
        TAP_PAU_DR  = 4'h6,
        TAP_EX2_DR  = 4'h7,
        TAP_UPD_DR  = 4'h8,
        TAP_SEL_IR  = 4'h9,
        TAP_CAP_IR  = 4'ha,
        TAP_SH_IR   = 4'hb,
        TAP_EX1_IR  = 4'hc,
        TAP_PAU_IR  = 4'hd,
        TAP_EX2_IR  = 4'he,
        TAP_UPD_IR  = 4'hf
    } tap_state_t;
endpackage

/* File: sram_wr_fifo.sv */
// Write data FIFO between pin capture and the storage array
`timescale 1ns/1ns
`default_nettype none
module sram_wr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             i_sys_clk,
    input  wire logic             i_rst_n,
    input  wire logic             i_valid,
    output logic                  o_ready,
    input  wire logic [WIDTH-1:0] i_data,
    output logic                  o_valid,
    input  wire logic             i_ready,
    output logic      [WIDTH-1:0] o_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_ptr_q;
    logic [AW:0]      rd_ptr_q;
    wire              full  = (wr_ptr_q[AW] != rd_ptr_q[AW]) &&
                              (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
    wire              empty = (wr_ptr_q == rd_ptr_q);
    wire              push  = i_valid && !full;
    wire              pop   = i_ready && !empty;

    assign o_ready = !full;
    assign o_valid = !empty;
    assign o_data  = mem_q[rd_ptr_q[AW-1:0]];

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else begin
            wr_ptr_q <= wr_ptr_q + (AW+1)'(push);
            rd_ptr_q <= rd_ptr_q + (AW+1)'(pop);
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (push) begin
            mem_q[wr_ptr_q[AW-1:0]] <= i_data;
        end
    end
endmodule // sram_wr_fifo
`default_nettype wire

/* File: sram_scan_port.sv */
// Boundary-scan test access port state machine and serial path
`timescale 1ns/1ns
`default_nettype none
module sram_scan_port
    import sram_pin_pkg::*;
(
    input  wire logic i_sys_clk,
    input  wire logic i_rst_n,
    input  wire logic i_tck,
    input  wire logic i_tms,
    input  wire logic i_tdi,
    output logic      o_tdo,
    output logic      o_tdo_oe
);
    logic [2:0]      s1_q;
    logic [2:0]      s2_q;
    logic            tck_prev_q;
    tap_state_t      state_q;
    tap_state_t      state_d;
    logic [IR_W-1:0] ir_q;
    logic            byp_q;
    logic            tdo_q;
    logic            tdo_oe_q;

    wire tck_s  = s2_q[0];
    wire tms_s  = s2_q[1];
    wire tdi_s  = s2_q[2];
    wire rise   = tck_s && !tck_prev_q;
    wire fall   = !tck_s && tck_prev_q;
    wire sh_ir  = (state_q == TAP_SH_IR);
    wire sh_dr  = (state_q == TAP_SH_DR);

    assign o_tdo    = tdo_q;
    assign o_tdo_oe = tdo_oe_q;

    always_comb begin
        state_d = state_q;
        case (state_q)
            TAP_RESET:  state_d = tms_s ? TAP_RESET  : TAP_IDLE;
            TAP_IDLE:   state_d = tms_s ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: state_d = tms_s ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: state_d = tms_s ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR:  state_d = tms_s ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: state_d = tms_s ? TAP_UPD_DR : TAP_PAU_DR;
            TAP_PAU_DR: state_d = tms_s ? TAP_EX2_DR : TAP_PAU_DR;
            TAP_EX2_DR: state_d = tms_s ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: state_d = tms_s ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: state_d = tms_s ? TAP_RESET  : TAP_CAP_IR;
            TAP_CAP_IR: state_d = tms_s ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR:  state_d = tms_s ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: state_d = tms_s ? TAP_UPD_IR : TAP_PAU_IR;
            TAP_PAU_IR: state_d = tms_s ? TAP_EX2_IR : TAP_PAU_IR;
            TAP_EX2_IR: state_d = tms_s ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: state_d = tms_s ? TAP_SEL_DR : TAP_IDLE;
            default:    state_d = TAP_RESET;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s1_q       <= '0;
            s2_q       <= '0;
            tck_prev_q <= 1'b0;
        end else begin
            s1_q       <= {i_tdi, i_tms, i_tck};
            s2_q       <= s1_q;
            tck_prev_q <= tck_s;
        end
    end

    // Test clock rising edge: state step and input sampling
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= TAP_RESET;
            ir_q    <= IR_CAPTURE;
            byp_q   <= 1'b0;
        end else if (rise) begin
            state_q <= state_d; // RULE12
            if (state_q == TAP_CAP_IR) begin
                ir_q <= IR_CAPTURE;
            end else if (sh_ir) begin
                ir_q <= {tdi_s, ir_q[IR_W-1:1]}; // RULE12
            end
            if (state_q == TAP_CAP_DR) begin
                byp_q <= 1'b0;
            end else if (sh_dr) begin
                byp_q <= tdi_s; // RULE12
            end
        end
    end

    // Test clock falling edge: serial output update
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tdo_q    <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else if (fall) begin
            tdo_q    <= sh_ir ? ir_q[0] : byp_q; // RULE11
            tdo_oe_q <= sh_ir || sh_dr;
        end
    end

    tap_step_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RULE12
        rise |=> state_q == $past(state_d))
        else $error("scan state did not step on test clock rise");

    tdo_edge_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RULE11
        ($changed(o_tdo) || $changed(o_tdo_oe)) |-> $past(fall))
        else $error("serial output changed away from test clock fall");
endmodule // sram_scan_port
`default_nettype wire

/* File: sram_pin_ctrl.sv */
// Pin-level control of a synchronous pipelined burst SRAM
// Behaviour
// RULE1: Output enable low lets data and parity pins drive; high makes them inputs.
// RULE2: Outputs off during write data, first clock after deselect, and while deselected.
// RULE3: Act on clock edges only while clock qualify is low; otherwise hold all state. Queued writes still drain from the write FIFO into storage.
// RULE4: Clock qualify high never deselects; it stretches the cycle in progress.
// RULE5: Data and parity pins are captured into a data register at clock rise.
// RULE6: Read drives the word at the address sampled at the previous edge.
// RULE7: Parity lanes behave as data; each written only under its byte write select.
// RULE8: Burst strap high selects interleaved order, low selects linear order.
// RULE9: Unconnected burst strap counts as high, giving interleaved order.
// RULE10: System keeps the burst strap constant during operation.
// RULE11: Serial test output changes on the falling test clock edge.
// RULE12: Test mode select and test data in sampled on rising test clock edge.
// RULE13: Sleep request enters low-power sleep keeping all stored data.
// RULE14: Sleep request low or open for normal use; internal pull-down.
// RULE15: Entering or leaving sleep takes two clock cycles after the request changes.
// RULE16: Selected only with first and third selects low and second high.
// RULE17: Advance high steps the burst counter; low loads a new address.
// RULE18: Controller releases the shared data bus before read data may drive.
// RULE19: Read data appears after the edge following the address sample, holds one cycle.
`timescale 1ns/1ns
`default_nettype none
module sram_pin_ctrl
    import sram_pin_pkg::*;
#(
    parameter int AW = ADDR_W
) (
    input  wire logic              i_sys_clk,
    input  wire logic              i_rst_n,
    input  wire logic              i_clock_qualify_n,
    input  wire logic              i_chip_select_first_n,
    input  wire logic              i_chip_select_second,
    input  wire logic              i_chip_select_third_n,
    input  wire logic              i_advance_or_load,
    input  wire logic              i_write_n,
    input  wire logic [LANES-1:0]  i_byte_write_select_n,
    input  wire logic [AW-1:0]     i_addr,
    input  wire data_word_t        i_dq,
    output data_word_t             o_dq,
    output logic                   o_dq_oe,
    input  wire logic              i_out_enable_n,
    input  wire logic              i_burst_mode,
    input  wire logic              i_sleep_request,
    output logic                   o_sleep,
    input  wire logic              i_tck,
    input  wire logic              i_tms,
    input  wire logic              i_tdi,
    output logic                   o_tdo,
    output logic                   o_tdo_oe
);
    typedef struct packed {
        logic [AW-1:0]    addr;
        logic [LANES-1:0] byte_write_select_n;
        data_word_t       word;
    } entry_t;

    logic               rst_s1_q;
    logic               rst_n_q;
    logic [2:0]         async_s1_q;
    logic [2:0]         async_s2_q;
    logic               mode_q;
    logic [1:0]         caught_q;
    logic               sleep_q;
    logic [1:0]         sleep_cnt_q;
    logic [AW-1:0]      base_q;
    logic [BURST_W-1:0] cnt_q;
    logic               burst_act_q;
    logic               burst_wr_q;
    logic               a_valid_q;
    logic               a_write_q;
    logic [AW-1:0]      a_addr_q;
    logic [LANES-1:0]   a_bw_q;
    logic               b_valid_q;
    logic               b_write_q;
    logic [AW-1:0]      b_addr_q;
    logic [LANES-1:0]   b_bw_q;
    logic               read_phase_q;
    logic               drive_q;
    data_word_t         out_q;
    logic               wr_push_q;
    entry_t             entry_q;
    entry_t             drain;
    data_word_t         rd_word;
    logic               fifo_in_ready;
    logic               fifo_out_valid;

    // Input decode and burst address
    wire                oe_n_s     = async_s2_q[SYNC_OE];
    wire                sleep_s    = async_s2_q[SYNC_SLEEP];
    wire                fifo_block = wr_push_q && !fifo_in_ready;
    wire                en         = !i_clock_qualify_n && !sleep_q && !fifo_block; // RULE3
    wire                selected   = !i_chip_select_first_n && i_chip_select_second &&
                                     !i_chip_select_third_n; // RULE16
    wire                load       = !i_advance_or_load;
    wire [BURST_W-1:0]  cnt_d      = load ? BURST_START : cnt_q + BURST_STEP; // RULE17
    wire                act_d      = load ? selected : burst_act_q; // RULE16
    wire                wr_d       = load ? !i_write_n : burst_wr_q;
    wire [AW-1:0]       base_d     = load ? i_addr : base_q;
    wire [BURST_W-1:0]  low_d      = mode_q ? (base_d[BURST_W-1:0] ^ cnt_d)
                                            : (base_d[BURST_W-1:0] + cnt_d); // RULE8
    wire [AW-1:0]       eff_addr   = {base_d[AW-1:BURST_W], low_d};
    wire                rp_d       = en ? (a_valid_q && !a_write_q && b_valid_q)
                                        : read_phase_q; // RULE2 RULE4
    wire                drain_ok   = fifo_out_valid && !sleep_q; // RULE13

    assign o_dq    = out_q;
    assign o_dq_oe = drive_q;
    assign o_sleep = sleep_q;

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    // Asynchronous pins: output enable, sleep request, burst strap
    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            async_s1_q <= ASYNC_RST_VAL; // RULE14
            async_s2_q <= ASYNC_RST_VAL;
        end else begin
            async_s1_q <= {i_burst_mode, i_sleep_request, i_out_enable_n};
            async_s2_q <= async_s1_q;
        end
    end

    // Strap caught once after reset release
    // Waits until the pin, not the reset value, has passed both sync stages
    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            mode_q   <= 1'b1; // RULE9
            caught_q <= 2'h0;
        end else if (caught_q != 2'h3) begin
            mode_q   <= async_s2_q[SYNC_MODE]; // RULE8 RULE10
            caught_q <= caught_q + 2'h1;
        end
    end

    // Sleep entry and exit delay
    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            sleep_q     <= 1'b0;
            sleep_cnt_q <= 2'h0;
        end else if (sleep_s == sleep_q) begin
            sleep_cnt_q <= 2'h0;
        end else if (sleep_cnt_q == SLEEP_LAST) begin
            sleep_q     <= sleep_s; // RULE13 RULE15
            sleep_cnt_q <= 2'h0;
        end else begin
            sleep_cnt_q <= sleep_cnt_q + 2'h1;
        end
    end

    // Burst counter and address stage
    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            base_q      <= '0;
            cnt_q       <= BURST_START;
            burst_act_q <= 1'b0;
            burst_wr_q  <= 1'b0;
            a_valid_q   <= 1'b0;
            a_write_q   <= 1'b0;
            a_addr_q    <= '0;
            a_bw_q      <= '1;
        end else if (en) begin
            base_q      <= base_d; // RULE17
            cnt_q       <= cnt_d;
            burst_act_q <= act_d;
            burst_wr_q  <= wr_d;
            a_valid_q   <= act_d;
            a_write_q   <= wr_d;
            a_addr_q    <= eff_addr;
            a_bw_q      <= i_byte_write_select_n;
        end
    end

    // Data phase stage and write capture
    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            b_valid_q <= 1'b0;
            b_write_q <= 1'b0;
            b_addr_q  <= '0;
            b_bw_q    <= '1;
            wr_push_q <= 1'b0;
            entry_q   <= '0;
        end else if (en) begin
            b_valid_q <= a_valid_q;
            b_write_q <= a_write_q;
            b_addr_q  <= a_addr_q;
            b_bw_q    <= a_bw_q;
            wr_push_q <= b_valid_q && b_write_q;
            entry_q   <= '{addr: b_addr_q, byte_write_select_n: b_bw_q, word: i_dq}; // RULE5
        end else if (fifo_in_ready) begin
            wr_push_q <= 1'b0;
        end
    end

    // Output register and drive enable
    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            out_q        <= '0;
            read_phase_q <= 1'b0;
            drive_q      <= 1'b0;
        end else begin
            read_phase_q <= rp_d;
            drive_q      <= rp_d && !oe_n_s && !sleep_q; // RULE1 RULE2
            if (en && a_valid_q && !a_write_q) begin
                out_q <= rd_word; // RULE6 RULE19
            end
        end
    end

    sram_wr_fifo #(
        .WIDTH ($bits(entry_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_wr_fifo (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (rst_n_q),
        .i_valid   (wr_push_q),
        .o_ready   (fifo_in_ready),
        .i_data    (entry_q),
        .o_valid   (fifo_out_valid),
        .i_ready   (!sleep_q),
        .o_data    (drain)
    );

    // Storage, one array per byte lane with its parity bit
    for (genvar l = 0; l < LANES; l++) begin : g_lane
        logic [LANE_W:0] lane_mem_q [2**AW];
        wire             lane_we = drain_ok && !drain.byte_write_select_n[l]; // RULE7

        assign rd_word.data_lines[l*LANE_W +: LANE_W] = lane_mem_q[a_addr_q][LANE_W-1:0];
        assign rd_word.parity_lines[l]                = lane_mem_q[a_addr_q][LANE_W];

        always_ff @(posedge i_sys_clk) begin
            if (lane_we) begin
                lane_mem_q[drain.addr] <= {drain.word.parity_lines[l],
                                           drain.word.data_lines[l*LANE_W +: LANE_W]};
            end
        end
    end

    sram_scan_port u_scan (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (rst_n_q),
        .i_tck     (i_tck),
        .i_tms     (i_tms),
        .i_tdi     (i_tdi),
        .o_tdo     (o_tdo),
        .o_tdo_oe  (o_tdo_oe)
    );

    oe_gate_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q) // RULE1
        o_dq_oe |-> !$past(oe_n_s))
        else $error("data driven while output enable was high");

    wr_quiet_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q) // RULE2
        (b_valid_q && b_write_q) |-> !o_dq_oe)
        else $error("data driven during write data phase");

    hold_state_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q) // RULE3
        !en |=> $stable(a_addr_q) && $stable(cnt_q) && $stable(a_valid_q))
        else $error("state moved while clock not qualified");

    read_data_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q) // RULE6
        (en && a_valid_q && !a_write_q) |=> o_dq == $past(rd_word))
        else $error("read data not from sampled address");

    select_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q) // RULE16
        (en && !i_advance_or_load) |=> a_valid_q == $past(selected) && a_addr_q == $past(i_addr))
        else $error("load did not follow chip selects and address");

    linear_step_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q) // RULE8
        (en && i_advance_or_load && !mode_q) |=>
        a_addr_q[1:0] == $past(a_addr_q[1:0]) + 2'h1)
        else $error("linear burst did not step by one");

    capture_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q) // RULE5
        (en && b_valid_q && b_write_q) |=> wr_push_q && entry_q.word == $past(i_dq))
        else $error("write data not captured at data edge");

    sleep_delay_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q) // RULE15
        $changed(sleep_q) |-> $past(sleep_s) != $past(sleep_q) &&
        $past(sleep_s, 2) != $past(sleep_q, 2))
        else $error("sleep changed without two cycles of request");

    emerge_mask_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q) // RULE2
        (en && !b_valid_q) |=> !o_dq_oe)
        else $error("data driven right after deselect");

    sleep_hold_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n_q) // RULE13
        sleep_q |=>
        !o_dq_oe && $stable(a_addr_q))
        else $error("activity during sleep");
endmodule // sram_pin_ctrl
`default_nettype wire

/* File: sram_host_model.sv */
// Memory controller model that drives the SRAM pins and resolves the data bus
`timescale 1ns/1ns
`default_nettype none
module sram_host_model
    import sram_pin_pkg::*;
(
    input  wire logic               i_sys_clk,
    input  wire data_word_t         i_dq_out,
    input  wire logic               i_dq_oe,
    output logic                    o_clock_qualify_n,
    output logic                    o_chip_select_first_n,
    output logic                    o_chip_select_second,
    output logic                    o_chip_select_third_n,
    output logic                    o_advance_or_load,
    output logic                    o_write_n,
    output logic [LANES-1:0]        o_byte_write_select_n,
    output logic [ADDR_W-1:0]       o_addr,
    output data_word_t              o_bus
);
    logic       cur_wr = 1'b0;
    logic       wv0    = 1'b0;
    logic       wv1    = 1'b0;
    logic       dv     = 1'b0;
    data_word_t cur_d  = '0;
    data_word_t wd0    = '0;
    data_word_t wd1    = '0;
    data_word_t dd     = '0;
    data_word_t idle   = 36'h5_a5a5_a5a5;

    initial o_clock_qualify_n = 1'b1;

    // Write data follows its load by two qualified edges
    always @(posedge i_sys_clk) begin
        if (!o_clock_qualify_n) begin
            wv0 <= cur_wr;
            wd0 <= cur_d;
            wv1 <= wv0;
            wd1 <= wd0;
        end
    end
    always @(negedge i_sys_clk) begin
        dv   <= wv1;
        dd   <= wd1;
        idle <= ~idle;
    end
    assign o_bus = i_dq_oe ? i_dq_out : (dv ? dd : idle);

    task automatic cmd(input logic adv, input logic [2:0] cs, input logic wr_n,
                       input logic [ADDR_W-1:0] a, input logic [3:0] bw, input data_word_t d);
        @(negedge i_sys_clk);
        o_clock_qualify_n = 1'b0;
        {o_chip_select_first_n, o_chip_select_second, o_chip_select_third_n} = cs;
        o_advance_or_load     = adv;
        o_write_n             = wr_n;
        o_addr                = a;
        o_byte_write_select_n = bw;
        cur_wr                = !adv && cs == 3'h2 && !wr_n;
        cur_d                 = d;
    endtask

    task automatic hold(input int n);
        @(negedge i_sys_clk);
        o_clock_qualify_n = 1'b1;
        repeat (n - 1) @(negedge i_sys_clk);
    endtask
endmodule // sram_host_model
`default_nettype wire

/* File: pipelined_sram_pin_control_tb_top.sv */
// Self-checking testbench for the SRAM pin control
`timescale 1ns/1ns
`default_nettype none
module pipelined_sram_pin_control_tb_top
    import sram_pin_pkg::*;
;
    localparam logic [2:0]  SEL  = 3'h2;
    localparam logic [2:0]  DES  = 3'h6;
    localparam logic [17:0] A1   = 18'h00010;
    localparam logic [17:0] A2   = 18'h3ffff;
    localparam logic [17:0] A3   = 18'h00020;
    localparam logic [17:0] BASE = 18'h00100;
    logic clk = 1'b0, rst_n = 1'b0, out_enable_n = 1'b0, burst_mode = 1'b1;
    logic sleep_request = 1'b0, tck = 1'b0, tms = 1'b1, tdi = 1'b0;
    logic qn, cs1_n, cs2, cs3_n, adv, wr_n, dq_oe, sleep, tdo, tdo_oe;
    logic [3:0]  bw_n;
    logic [17:0] addr;
    data_word_t  bus, dq_out;
    data_word_t  exp_mem [logic [17:0]];
    int bad_count = 0, tests_run = 0, cycles = 0;

    initial forever #5 clk = ~clk;

    sram_host_model h (.i_sys_clk(clk), .i_dq_out(dq_out), .i_dq_oe(dq_oe),
        .o_clock_qualify_n(qn), .o_chip_select_first_n(cs1_n), .o_chip_select_second(cs2),
        .o_chip_select_third_n(cs3_n), .o_advance_or_load(adv), .o_write_n(wr_n),
        .o_byte_write_select_n(bw_n), .o_addr(addr), .o_bus(bus));

    sram_pin_ctrl dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_clock_qualify_n(qn),
        .i_chip_select_first_n(cs1_n), .i_chip_select_second(cs2),
        .i_chip_select_third_n(cs3_n), .i_advance_or_load(adv), .i_write_n(wr_n),
        .i_byte_write_select_n(bw_n), .i_addr(addr), .i_dq(bus), .o_dq(dq_out),
        .o_dq_oe(dq_oe), .i_out_enable_n(out_enable_n), .i_burst_mode(burst_mode),
        .i_sleep_request(sleep_request), .o_sleep(sleep), .i_tck(tck), .i_tms(tms),
        .i_tdi(tdi), .o_tdo(tdo), .o_tdo_oe(tdo_oe));

    task automatic final_report();
        if (bad_count == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [35:0] seen, input logic [35:0] want);
        tests_run++;
        if (seen !== want) begin
            bad_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic rst(input logic m);
        rst_n = 1'b0;
        burst_mode = m;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
    endtask

    task automatic nop(input int n);
        repeat (n) h.cmd(1'b0, DES, 1'b1, '0, 4'hf, '0);
    endtask

    task automatic wr(input logic [17:0] a, input logic [3:0] bw, input data_word_t d);
        data_word_t e;
        e = exp_mem.exists(a) ? exp_mem[a] : 'x;
        h.cmd(1'b0, SEL, 1'b0, a, bw, d);
        for (int l = 0; l < LANES; l++) begin
            if (!bw[l]) begin
                e.data_lines[l*8+:8] = d.data_lines[l*8+:8];
                e.parity_lines[l]    = d.parity_lines[l];
            end
        end
        exp_mem[a] = e;
        nop(4);
    endtask

    task automatic rd(input logic [17:0] a);
        h.cmd(1'b0, SEL, 1'b1, a, 4'hf, '0);
        nop(2);
        chk(dq_out, exp_mem[a]);
    endtask

    // Second read lands in the slot after a live read, so only selects and enable mask it
    task automatic t_sel(input logic [2:0] cs, input logic oe_hi);
        out_enable_n = oe_hi;
        nop(4);
        h.cmd(1'b0, SEL, 1'b1, A1, 4'hf, '0);
        h.cmd(1'b0, cs, 1'b1, A2, 4'hf, '0);
        nop(2);
        chk(dq_oe, cs == SEL && !oe_hi);
        chk(dq_out, exp_mem[cs == SEL ? A2 : A1]);
        out_enable_n = 1'b0;
    endtask

    task automatic t_wphase();
        h.cmd(1'b0, SEL, 1'b1, A1, 4'hf, '0);
        h.cmd(1'b0, SEL, 1'b1, A2, 4'hf, '0);
        h.cmd(1'b0, SEL, 1'b0, A3, 4'h0, 36'h9_1357_9bdf);
        exp_mem[A3] = 36'h9_1357_9bdf;
        nop(1);
        chk(dq_oe, 1'b1);
        nop(1);
        chk(dq_oe, 1'b0);
        nop(3);
        rd(A3);
    endtask

    task automatic t_qualify();
        rd(A1);
        h.cmd(1'b0, SEL, 1'b1, A2, 4'hf, '0);
        h.hold(3);
        chk(dq_out, exp_mem[A1]);
        nop(2);
        chk(dq_out, exp_mem[A2]);
    endtask

    task automatic t_sleep();
        sleep_request = 1'b1;
        repeat (3) @(negedge clk);
        chk(sleep, 1'b0);
        repeat (1) @(negedge clk);
        chk(sleep, 1'b1);
        sleep_request = 1'b0;
        repeat (3) @(negedge clk);
        chk(sleep, 1'b1);
        repeat (1) @(negedge clk);
        chk(sleep, 1'b0);
        rd(A1);
    endtask

    task automatic t_burst(input logic m);
        logic [1:0] lo;
        rst(m);
        for (int k = 0; k < 4; k++) wr(BASE + 18'(k), 4'h0, {4'(k + 1), 32'h7e000000 + 32'(k)});
        h.cmd(1'b0, SEL, 1'b1, BASE + 18'h1, 4'hf, '0);
        for (int k = 0; k < 5; k++) begin
            h.cmd(k < 3, k < 3 ? SEL : DES, 1'b1, '0, 4'hf, '0);
            lo = m ? (2'h1 ^ 2'(k - 1)) : (2'h1 + 2'(k - 1));
            if (k > 0) chk(dq_out, exp_mem[{BASE[17:2], lo}]);
        end
    endtask

    task automatic tstep(input logic ms, input logic di);
        tms = ms;
        tdi = di;
        repeat (8) @(negedge clk);
        tck = 1'b1;
        repeat (8) @(negedge clk);
        tck = 1'b0;
        repeat (8) @(negedge clk);
    endtask

    task automatic t_scan();
        logic [3:0] bits;
        bits = 4'hd;
        repeat (5) tstep(1'b1, 1'b0);
        tstep(1'b0, 1'b0);
        tstep(1'b1, 1'b0);
        tstep(1'b0, 1'b0);
        tstep(1'b0, 1'b0);
        chk(tdo_oe, 1'b1);
        chk(tdo, 1'b0);
        for (int i = 0; i < 4; i++) begin
            tstep(1'b0, bits[i]);
            chk(tdo, bits[i]);
        end
        tstep(1'b1, 1'b0);
        tstep(1'b1, 1'b0);
        repeat (2) tstep(1'b1, 1'b0);
        repeat (2) tstep(1'b0, 1'b0);
        chk(tdo, IR_CAPTURE[0]);
        tstep(1'b0, 1'b1);
        tstep(1'b0, 1'b0);
        chk(tdo, 1'b1);
    endtask

    // Cuts a hang short
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            final_report();
        end
    end

    initial begin
        rst(1'b1);
        wr(A1, 4'h0, 36'h3_0123_4567);
        wr(A2, 4'h0, 36'hf_ffff_ffff);
        wr(A2, 4'ha, 36'h0_0000_0000);
        rd(A2);
        t_sel(SEL, 1'b0);
        t_sel(3'h6, 1'b0);
        t_sel(3'h0, 1'b0);
        t_sel(3'h3, 1'b0);
        t_sel(SEL, 1'b1);
        t_wphase();
        t_qualify();
        t_sleep();
        t_scan();
        t_burst(1'b1);
        t_burst(1'b0);
        final_report();
    end
endmodule // pipelined_sram_pin_control_tb_top
`default_nettype wire
